/* File: scm_pkg.sv */
// Purpose: Shared constants and types of the system control register bank
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   Masks mark the writable bits; all other bits read as zero except the USB PHY status bits 8 and 5
package scm_pkg;

    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          STRB_W         = 4;
    localparam int          SYNC_W         = 7;

    localparam logic [11:0] OFF_TIMER_SEL  = 12'h000;
    localparam logic [11:0] OFF_USB_PHY    = 12'h004;
    localparam logic [11:0] OFF_GEN_CTRL   = 12'h008;
    localparam logic [11:0] OFF_PRIO_0     = 12'h00C;
    localparam logic [11:0] OFF_PRIO_1     = 12'h010;

    localparam logic [31:0] MASK_TIMER_SEL = 32'h0000_0003;
    localparam logic [31:0] MASK_USB_PHY   = 32'h0000_0ED7;
    localparam logic [31:0] MASK_GEN_CTRL  = 32'h0000_0013;
    localparam logic [31:0] MASK_PRIO_0    = 32'h0000_0077;
    localparam logic [31:0] MASK_PRIO_1    = 32'h0000_0700;

    localparam logic [31:0] RST_TIMER_SEL  = 32'h0000_0000;
    localparam logic [31:0] RST_USB_PHY    = 32'h0000_0000;
    localparam logic [31:0] RST_GEN_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_PRIO_0     = 32'h0000_0011;
    localparam logic [31:0] RST_PRIO_1     = 32'h0000_0400;

    localparam int          BIT_TIN_A      = 0;
    localparam int          BIT_TIN_B      = 1;
    localparam int          BIT_DATA_INV   = 11;
    localparam int          BIT_CLK_SRC_HI = 10;
    localparam int          BIT_CLK_SRC_LO = 9;
    localparam int          BIT_PHY_GOOD   = 8;
    localparam int          BIT_SESS_EN    = 7;
    localparam int          BIT_VBUS_EN    = 6;
    localparam int          BIT_VBUS_PRES  = 5;
    localparam int          BIT_PLL_ON     = 4;
    localparam int          BIT_VID_OSC_PD = 2;
    localparam int          BIT_OTG_PD     = 1;
    localparam int          BIT_PHY_PD     = 0;
    localparam int          BIT_WDOG       = 4;
    localparam int          BIT_POST_DIV   = 1;
    localparam int          BIT_ZERO_WAIT  = 0;
    localparam int          BIT_CFG_PRI_HI = 6;
    localparam int          BIT_CFG_PRI_LO = 4;
    localparam int          BIT_DAT_PRI_HI = 2;
    localparam int          BIT_DAT_PRI_LO = 0;
    localparam int          BIT_USB_PRI_HI = 10;
    localparam int          BIT_USB_PRI_LO = 8;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_RESP = 2'b01
    } scm_wr_state_t;

    typedef struct packed {
        logic       phy_data_invert;
        logic [1:0] phy_clock_source;
        logic       session_end_compare_enable;
        logic       bus_voltage_compare_enable;
        logic       phy_pll_keep_running;
        logic       video_oscillator_power_off;
        logic       otg_analog_power_off;
        logic       usb_phy_power_off;
        logic       timer_two_watchdog_mode;
        logic       main_pll_post_divide;
        logic       internal_ram_zero_wait;
        logic [2:0] cpu_config_port_priority;
        logic [2:0] cpu_data_port_priority;
        logic [2:0] usb_master_priority;
    } scm_ctrl_t;

    typedef struct packed {
        logic       bus_voltage_present;
        logic       phy_pll_locked;
        logic       phy_power_ramped;
        logic [3:0] gio;
    } scm_status_t;

endpackage

/* File: scm_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module scm_sync
    import scm_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [SYNC_W-1:0] async_in,
    output logic      [SYNC_W-1:0] sync_out
);

    logic [SYNC_W-1:0] stage1_reg;
    logic [SYNC_W-1:0] stage2_reg;
    logic [SYNC_W-1:0] stage3_reg;
    logic [SYNC_W-1:0] out_reg;
    logic [SYNC_W-1:0] out_next;

    // Per bit: a lone mismatch between the late stages is held off
    assign out_next = ((stage2_reg ~^ stage3_reg) & stage3_reg)
                    | ((stage2_reg ^ stage3_reg) & out_reg);
    assign sync_out = out_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            out_reg    <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg    <= out_next;
        end
    end

endmodule

/* File: scm_regs.sv */
// Purpose: System control register bank behind an AXI4-Lite slave
// Assumes: Single clock aclk, synchronous active-low reset aresetn
// Notes:   Status pins are filtered through scm_sync before use
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scm_regs
    import scm_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [STRB_W-1:0] s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic      [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic      [DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    input  wire logic [3:0]        gio_pin_in,
    input  wire logic              phy_power_ramped,
    input  wire logic              phy_pll_locked,
    input  wire logic              otg_vbus_sense,
    output logic                   timer_in_a,
    output logic                   timer_in_b,
    output scm_ctrl_t              ctrl
);

    function automatic logic word_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [11:0] off);
        word_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = word_hit(addr, OFF_TIMER_SEL) || word_hit(addr, OFF_USB_PHY)
                 || word_hit(addr, OFF_GEN_CTRL) || word_hit(addr, OFF_PRIO_0)
                 || word_hit(addr, OFF_PRIO_1);
    endfunction

    // Byte strobes and writable mask together; reserved bits never take data
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~m) | (data & m);
    endfunction

    scm_wr_state_t     wr_state_reg;
    scm_wr_state_t     wr_state_next;
    logic              aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              w_held_reg;
    logic [DATA_W-1:0] w_data_reg;
    logic [STRB_W-1:0] w_strb_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0]        rresp_reg;
    logic [31:0]       tsel_reg;
    logic [31:0]       usb_reg;
    logic [31:0]       gen_reg;
    logic [31:0]       pri0_reg;
    logic [31:0]       pri1_reg;
    logic              timer_a_reg;
    logic              timer_b_reg;
    logic [31:0]       rd_word;
    logic [31:0]       usb_view;
    scm_status_t       st_raw;
    scm_status_t       st_sync;
    logic              phy_good;
    logic              wr_fire;
    logic              ar_fire;
    logic              wr_tsel;
    logic              wr_usb;
    logic              wr_gen;
    logic              wr_pri0;
    logic              wr_pri1;

    assign st_raw = '{bus_voltage_present: otg_vbus_sense,
                      phy_pll_locked:      phy_pll_locked,
                      phy_power_ramped:    phy_power_ramped,
                      gio:                 gio_pin_in};

    scm_sync u_sync
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (st_raw),
        .sync_out (st_sync)
    );

    assign phy_good = st_sync.phy_power_ramped & st_sync.phy_pll_locked;

    // Write channel: address and data latch independently, then commit
    assign s_axi_awready = !aw_held_reg && (wr_state_reg == WS_IDLE);
    assign s_axi_wready  = !w_held_reg && (wr_state_reg == WS_IDLE);
    assign wr_fire       = aw_held_reg && w_held_reg && (wr_state_reg == WS_IDLE);
    assign wr_tsel       = wr_fire && word_hit(aw_addr_reg, OFF_TIMER_SEL);
    assign wr_usb        = wr_fire && word_hit(aw_addr_reg, OFF_USB_PHY);
    assign wr_gen        = wr_fire && word_hit(aw_addr_reg, OFF_GEN_CTRL);
    assign wr_pri0       = wr_fire && word_hit(aw_addr_reg, OFF_PRIO_0);
    assign wr_pri1       = wr_fire && word_hit(aw_addr_reg, OFF_PRIO_1);
    assign s_axi_bvalid  = (wr_state_reg == WS_RESP);
    assign s_axi_bresp   = bresp_reg;

    always_comb
    begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            WS_IDLE:
            begin
                if (wr_fire)
                    wr_state_next = WS_RESP;
            end
            WS_RESP:
            begin
                if (s_axi_bready)
                    wr_state_next = WS_IDLE;
            end
            default:
                wr_state_next = WS_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_reg <= WS_IDLE;
            aw_held_reg  <= 1'b0;
            aw_addr_reg  <= '0;
            w_held_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            bresp_reg    <= RESP_OKAY;
        end
        else
        begin
            wr_state_reg <= wr_state_next;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
            if (wr_fire)
                bresp_reg <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Register storage; only masked bits ever become nonzero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tsel_reg <= RST_TIMER_SEL;
            usb_reg  <= RST_USB_PHY;
            gen_reg  <= RST_GEN_CTRL;
            pri0_reg <= RST_PRIO_0;
            pri1_reg <= RST_PRIO_1;
        end
        else
        begin
            if (wr_tsel)
                tsel_reg <= merge(tsel_reg, w_data_reg, w_strb_reg, MASK_TIMER_SEL);
            if (wr_usb)
                usb_reg <= merge(usb_reg, w_data_reg, w_strb_reg, MASK_USB_PHY);
            if (wr_gen)
                gen_reg <= merge(gen_reg, w_data_reg, w_strb_reg, MASK_GEN_CTRL);
            if (wr_pri0)
                pri0_reg <= merge(pri0_reg, w_data_reg, w_strb_reg, MASK_PRIO_0);
            if (wr_pri1)
                pri1_reg <= merge(pri1_reg, w_data_reg, w_strb_reg, MASK_PRIO_1);
        end
    end

    // Status bits are spliced in at read time and cannot be written
    always_comb
    begin
        usb_view                = usb_reg;
        usb_view[BIT_PHY_GOOD]  = phy_good;
        usb_view[BIT_VBUS_PRES] = st_sync.bus_voltage_present;
    end

    always_comb
    begin
        if (word_hit(s_axi_araddr, OFF_TIMER_SEL))
            rd_word = tsel_reg;
        else if (word_hit(s_axi_araddr, OFF_USB_PHY))
            rd_word = usb_view;
        else if (word_hit(s_axi_araddr, OFF_GEN_CTRL))
            rd_word = gen_reg;
        else if (word_hit(s_axi_araddr, OFF_PRIO_0))
            rd_word = pri0_reg;
        else if (word_hit(s_axi_araddr, OFF_PRIO_1))
            rd_word = pri1_reg;
        else
            rd_word = 32'h0000_0000;
    end

    assign s_axi_arready = !rvalid_reg;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // Timer inputs are registered so both routes share one latency
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_a_reg <= 1'b0;
            timer_b_reg <= 1'b0;
        end
        else
        begin
            timer_a_reg <= tsel_reg[BIT_TIN_A] ? st_sync.gio[1] : st_sync.gio[0];
            timer_b_reg <= tsel_reg[BIT_TIN_B] ? st_sync.gio[3] : st_sync.gio[2];
        end
    end

    assign timer_in_a = timer_a_reg;
    assign timer_in_b = timer_b_reg;

    assign ctrl.phy_data_invert            = usb_reg[BIT_DATA_INV];
    assign ctrl.phy_clock_source           = usb_reg[BIT_CLK_SRC_HI:BIT_CLK_SRC_LO];
    assign ctrl.session_end_compare_enable = usb_reg[BIT_SESS_EN];
    assign ctrl.bus_voltage_compare_enable = usb_reg[BIT_VBUS_EN];
    assign ctrl.phy_pll_keep_running       = usb_reg[BIT_PLL_ON];
    assign ctrl.video_oscillator_power_off = usb_reg[BIT_VID_OSC_PD];
    assign ctrl.otg_analog_power_off       = usb_reg[BIT_OTG_PD];
    assign ctrl.usb_phy_power_off          = usb_reg[BIT_PHY_PD];
    assign ctrl.timer_two_watchdog_mode    = gen_reg[BIT_WDOG];
    assign ctrl.main_pll_post_divide       = gen_reg[BIT_POST_DIV];
    assign ctrl.internal_ram_zero_wait     = gen_reg[BIT_ZERO_WAIT];
    assign ctrl.cpu_config_port_priority   = pri0_reg[BIT_CFG_PRI_HI:BIT_CFG_PRI_LO];
    assign ctrl.cpu_data_port_priority     = pri0_reg[BIT_DAT_PRI_HI:BIT_DAT_PRI_LO];
    assign ctrl.usb_master_priority        = pri1_reg[BIT_USB_PRI_HI:BIT_USB_PRI_LO];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence full_word_write(logic [11:0] off);
        wr_fire && word_hit(aw_addr_reg, off) && (w_strb_reg == 4'hF);
    endsequence

    sequence read_of(logic [11:0] off);
        ar_fire && word_hit(s_axi_araddr, off);
    endsequence

    timer_a_route_a: assert property (##1 timer_in_a ==
        ($past(tsel_reg[BIT_TIN_A]) ? $past(st_sync.gio[1]) : $past(st_sync.gio[0])))
        else $error("timer input A routed from wrong pin");
    timer_b_route_a: assert property (##1 timer_in_b ==
        ($past(tsel_reg[BIT_TIN_B]) ? $past(st_sync.gio[3]) : $past(st_sync.gio[2])))
        else $error("timer input B routed from wrong pin");
    phy_ctrl_write_a: assert property (full_word_write(OFF_USB_PHY) |=>
        ctrl.phy_data_invert == $past(w_data_reg[BIT_DATA_INV])
        && ctrl.phy_clock_source == $past(w_data_reg[BIT_CLK_SRC_HI:BIT_CLK_SRC_LO])
        && ctrl.usb_phy_power_off == $past(w_data_reg[BIT_PHY_PD])
        && ctrl.otg_analog_power_off == $past(w_data_reg[BIT_OTG_PD]))
        else $error("PHY control field not taken from write");
    phy_good_read_a: assert property (read_of(OFF_USB_PHY) |=>
        s_axi_rdata[BIT_PHY_GOOD] == $past(st_sync.phy_power_ramped && st_sync.phy_pll_locked)
        && s_axi_rdata[BIT_VBUS_PRES] == $past(st_sync.bus_voltage_present))
        else $error("PHY status bits read wrong");
    gen_ctrl_write_a: assert property (full_word_write(OFF_GEN_CTRL) |=>
        ctrl.timer_two_watchdog_mode == $past(w_data_reg[BIT_WDOG])
        && ctrl.main_pll_post_divide == $past(w_data_reg[BIT_POST_DIV])
        && ctrl.internal_ram_zero_wait == $past(w_data_reg[BIT_ZERO_WAIT]))
        else $error("general control field not taken from write");
    prio_zero_write_a: assert property (full_word_write(OFF_PRIO_0) |=>
        ctrl.cpu_config_port_priority == $past(w_data_reg[BIT_CFG_PRI_HI:BIT_CFG_PRI_LO])
        && ctrl.cpu_data_port_priority == $past(w_data_reg[BIT_DAT_PRI_HI:BIT_DAT_PRI_LO]))
        else $error("priority 0 fields not taken from write");
    prio_one_read_a: assert property (read_of(OFF_PRIO_1) |=>
        s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:0] == 8'h00
        && s_axi_rdata[10:8] == $past(ctrl.usb_master_priority))
        else $error("priority 1 read shows reserved bits or wrong field");
    usb_reserved_a: assert property (read_of(OFF_USB_PHY) |=>
        s_axi_rdata[31:12] == 20'h0 && s_axi_rdata[3] == 1'b0)
        else $error("reserved PHY control bits not zero");
    write_answer_a: assert property (wr_fire |=> s_axi_bvalid
        ##0 (s_axi_bvalid throughout (!s_axi_bready [*1] or s_axi_bready [*1])))
        else $error("write response did not follow commit");
    status_hold_a: assert property (wr_usb |=> usb_reg[BIT_PHY_GOOD] == 1'b0
        && usb_reg[BIT_VBUS_PRES] == 1'b0)
        else $error("status bit stored by a write");

endmodule

/* File: scm_regs_bench.sv */
// Purpose: Self-checking bench for the system control register bank
// Assumes: AXI4-Lite master driven on rising edges, fixed LFSR seed
// Notes:   Expected values come from a bench model of the five registers
`timescale 1ns/1ps
module scm_regs_bench
    import scm_pkg::*;
;
    logic              aclk, aresetn;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [3:0]        gio_pin_in;
    logic              phy_power_ramped, phy_pll_locked, otg_vbus_sense;
    logic              timer_in_a, timer_in_b;
    scm_ctrl_t         ctrl;
    logic [31:0]       m [5];
    logic [31:0]       seed;
    logic [31:0]       pick;
    int                errors, checked;

    scm_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .gio_pin_in(gio_pin_in),
        .phy_power_ramped(phy_power_ramped), .phy_pll_locked(phy_pll_locked),
        .otg_vbus_sense(otg_vbus_sense), .timer_in_a(timer_in_a), .timer_in_b(timer_in_b),
        .ctrl(ctrl));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Index 5 and 6 are holes in the map
    function automatic logic [11:0] addr_of(int i);
        logic [11:0] a [7] = '{OFF_TIMER_SEL, OFF_USB_PHY, OFF_GEN_CTRL, OFF_PRIO_0,
                               OFF_PRIO_1, 12'h014, 12'hFFC};
        return a[i];
    endfunction

    function automatic logic [31:0] mask_of(int i);
        logic [31:0] a [5] = '{MASK_TIMER_SEL, MASK_USB_PHY, MASK_GEN_CTRL, MASK_PRIO_0,
                               MASK_PRIO_1};
        return a[i];
    endfunction

    function automatic logic [31:0] rd_exp(int i);
        logic [31:0] v;
        if (i > 4)
            return 32'h0000_0000;
        v = m[i];
        if (i == 1)
            v = v | ({31'h0, phy_power_ramped & phy_pll_locked} << 8)
                  | ({31'h0, otg_vbus_sense} << 5);
        return v;
    endfunction

    function automatic scm_ctrl_t ctrl_exp();
        scm_ctrl_t e;
        e.phy_data_invert            = m[1][11];
        e.phy_clock_source           = m[1][10:9];
        e.session_end_compare_enable = m[1][7];
        e.bus_voltage_compare_enable = m[1][6];
        e.phy_pll_keep_running       = m[1][4];
        e.video_oscillator_power_off = m[1][2];
        e.otg_analog_power_off       = m[1][1];
        e.usb_phy_power_off          = m[1][0];
        e.timer_two_watchdog_mode    = m[2][4];
        e.main_pll_post_divide       = m[2][1];
        e.internal_ram_zero_wait     = m[2][0];
        e.cpu_config_port_priority   = m[3][6:4];
        e.cpu_data_port_priority     = m[3][2:0];
        e.usb_master_priority        = m[4][10:8];
        return e;
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        m = '{RST_TIMER_SEL, RST_USB_PHY, RST_GEN_CTRL, RST_PRIO_0, RST_PRIO_1};
        // Let synchronisers settle before status is read
        repeat (8) @(posedge aclk);
    endtask

    // Read back, then compare register, response, control and timer mux
    task automatic look(int i);
        bit ar_ok;
        logic [31:0] d;
        logic [1:0] r;
        ar_ok = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= addr_of(i);
        s_axi_rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (!ar_ok && s_axi_arready === 1'b1)
            begin
                ar_ok = 1;
                s_axi_arvalid <= 1'b0;
            end
            else if (ar_ok && s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                // Ready stays up so back-to-back reads never drive it twice in a step
                break;
            end
        end
        chk("rdata", rd_exp(i), d);
        chk("rresp", {30'h0, (i > 4) ? RESP_SLVERR : RESP_OKAY}, {30'h0, r});
        chk("ctrl", {11'h0, ctrl_exp()}, {11'h0, ctrl});
        chk("timer_in_a", {31'h0, m[0][0] ? gio_pin_in[1] : gio_pin_in[0]}, {31'h0, timer_in_a});
        chk("timer_in_b", {31'h0, m[0][1] ? gio_pin_in[3] : gio_pin_in[2]}, {31'h0, timer_in_b});
    endtask

    task automatic put(int i, logic [31:0] d, logic [3:0] s);
        bit aw_ok, w_ok;
        logic [31:0] bm;
        logic [1:0] r;
        aw_ok = 0;
        w_ok  = 0;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= addr_of(i);
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1 && aw_ok && w_ok)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (!aw_ok && s_axi_awready === 1'b1)
            begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1)
            begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (i < 5)
            m[i] = ((m[i] & ~bm) | (d & bm)) & mask_of(i);
        chk("bresp", {30'h0, (i > 4) ? RESP_SLVERR : RESP_OKAY}, {30'h0, r});
        look(i);
    endtask

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {gio_pin_in, phy_power_ramped, phy_pll_locked, otg_vbus_sense} <= '0;
        errors  = 0;
        checked = 0;
        seed    = 32'h170FB96A;
        do_reset();
        for (int i = 0; i < 7; i++)
            look(i);
        $display("test reset values done");
        // Every clock source code, then all ones and all zeros
        for (int k = 0; k < 4; k++)
            put(1, (rnd() & ~32'h0000_0600) | (k << 9), 4'hF);
        for (int i = 0; i < 7; i++)
            put(i, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 5; i++)
            put(i, 32'h0000_0000, 4'hF);
        // Divider two and one wait state are safe for any grade and clock
        put(2, 32'h0000_0002, 4'hF);
        $display("test corner patterns done");
        for (int n = 0; n < 60; n++)
        begin
            pick = rnd();
            {gio_pin_in, phy_power_ramped, phy_pll_locked, otg_vbus_sense} <= pick[6:0];
            repeat (6) @(posedge aclk);
            pick = rnd();
            put(int'(pick % 7), rnd(), pick[7:4]);
        end
        $display("test random traffic done");
        do_reset();
        for (int i = 0; i < 5; i++)
            look(i);
        $display("test second reset done");
        tally_and_finish();
    end

    initial
    begin
        repeat (30000) @(posedge aclk);
        errors++;
        tally_and_finish();
    end
endmodule
